// ---- power_mode_pkg.sv ----
// shared constants and types for the power mode controller
package power_mode_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS  = 20;
	localparam int TICK_PERIOD_US = 1000;
	localparam int HWRST_TIME_US  = 1000;
	localparam logic [15:0] TIMEOUT_BASE_TICKS = 16'h0010;

	// register byte offsets
	localparam logic [11:0] CTRL_OFS     = 12'h000;
	localparam logic [11:0] XCFG_OFS     = 12'h004;
	localparam logic [11:0] LCFG_OFS     = 12'h008;
	localparam logic [11:0] STAT_OFS     = 12'h00c;
	localparam logic [11:0] SYSFLT_OFS   = 12'h010;
	localparam logic [11:0] COMMFLT1_OFS = 12'h014;
	localparam logic [11:0] COMMFLT3_OFS = 12'h018;

	// control_word_one fields
	localparam int SHUTDOWN_REQ_BIT = 0;
	localparam int SLEEP_REQ_BIT    = 1;
	// power_transition_config fields
	localparam int SLP_SEL_LSB      = 0;
	localparam int BAL_SHDN_EN_BIT  = 4;
	// link_idle_timeout_config fields
	localparam int LINK_SEL_LSB     = 0;
	localparam int LINK_EN_BIT      = 4;
	localparam int LINK_TO_SHDN_BIT = 5;
	// fault flag positions
	localparam int DIGITAL_RESET_FLAG_BIT         = 0;
	localparam int COMMCLR_BIT      = 0;
	localparam int FCOMM_BIT        = 0;
	// status fields
	localparam int STAT_MODE_LSB    = 0;
	localparam int STAT_FUNC_LSB    = 8;

	// reset values
	localparam logic [5:0]  XCFG_RST = 6'h00;
	localparam logic [5:0]  LCFG_RST = 6'h00;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

	typedef enum logic [4:0] {
		ST_POR      = 5'b0_0001,
		ST_SHUTDOWN = 5'b0_0010,
		ST_SLEEP    = 5'b0_0100,
		ST_ACTIVE   = 5'b0_1000,
		ST_HWRST    = 5'b1_0000
	} pwr_state_e;

	// per-mode function permissions
	typedef struct packed {
		logic adc;
		logic uart;
		logic vert_comm;
		logic comm_timeout;
		logic spi_ctrl;
		logic module_bal;
		logic otp_prog;
		logic cell_bal;
		logic protectors;
		logic fault_sig;
		logic sleep_timeout;
		logic therm_detect;
	} func_en_s;

	// asynchronous ping/tone and comparator indications
	typedef struct packed {
		logic wake;
		logic sleep_exit;
		logic shutdown;
		logic hard_reset;
		logic thermal;
	} pin_evt_s;

	localparam int PIN_EVT_W = $bits(pin_evt_s);
	localparam int FUNC_W    = $bits(func_en_s);

	// timeout select code to tick count, zero means disabled
	function automatic logic [15:0] timeout_ticks(input logic [2:0] sel);
		timeout_ticks = (sel == 3'h0) ? 16'h0000 : (TIMEOUT_BASE_TICKS << sel);
	endfunction : timeout_ticks

endpackage : power_mode_pkg

// ---- pin_sync.sv ----
// three-stage synchroniser with agreement filter and rise detect
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// asynchronous inputs
	input  wire logic [WIDTH-1:0] async_in,
	// filtered level and rising pulse
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] lvl_reg;
	logic [WIDTH-1:0] lvl_next;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// level follows only where stages two and three agree
	assign lvl_next = (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lvl_reg <= '0;
		end else begin
			lvl_reg <= lvl_next;
		end
	end

	assign level = lvl_reg;
	assign rise  = lvl_next & ~lvl_reg;
endmodule : pin_sync

// ---- idle_timer.sv ----
// tick-driven timeout counter, pulses on every tick once expired until restarted
`timescale 1ns/10ps
module idle_timer #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// control
	input  wire logic         tick,
	input  wire logic         run,
	input  wire logic         restart,
	input  wire logic [W-1:0] limit,
	// expiry pulse
	output logic              expired
);
	logic [W-1:0] count_reg;
	logic         hit;

	assign hit     = (limit != '0) && (count_reg == limit - W'(1));
	assign expired = run && !restart && tick && hit;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= '0;
		end else if (!run || restart) begin
			count_reg <= '0;
		end else if (tick && !hit) begin
			count_reg <= count_reg + W'(1);
		end
	end
endmodule : idle_timer

// ---- power_mode_controller.sv ----
// power mode state machine with apb register access
`timescale 1ns/10ps
// Function
// - after power-on reset the device settles in SHUTDOWN.
// - SHUTDOWN refuses register writes, waits only for a wake or hard-reset ping or tone.
// - base device wake from SHUTDOWN sets reset, upper comm and uart clear flags.
// - middle stack sets reset and upper comm flags; top sets reset flag only.
// - shutdown request bit written to 1 enters SHUTDOWN, also when broadcast.
// - enabled link idle timeout moves ACTIVE to SHUTDOWN.
// - enabled sleep timeout moves SLEEP to SHUTDOWN after configured time.
// - optionally enter SHUTDOWN once all cell balancing has finished.
// - die over-temperature indication forces SHUTDOWN.
// - shutdown ping or tone enters SHUTDOWN without communication.
// - hard-reset ping or tone turns circuits off, then restarts in SHUTDOWN.
// - SLEEP runs only balancing, protectors, fault signalling, sleep timeout, thermal.
// - SLEEP exits on wake (with reset) or sleep-exit (without reset).
// - SLEEP only from ACTIVE, via sleep request bit, also when broadcast.
// - enabled link idle timeout may instead move ACTIVE to SLEEP.
// - wake from SHUTDOWN reaches ACTIVE, resets registers, reloads shadow copies.
// - outside ACTIVE adc, uart, comm, comm timeout, spi, module balancing, otp are off.
// - sleep-exit in SLEEP wakes without reset, resets uart, sets uart clear flag on the base device.
// - wake ping or tone in ACTIVE performs a full digital reset.
module power_mode_controller
	import power_mode_pkg::*;
#(
	parameter int TICK_CYCLES  = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS,
	parameter int HWRST_CYCLES = HWRST_TIME_US * 1000 / CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// chain position
	input  wire logic        is_base,
	input  wire logic        is_top,
	// detectors, asynchronous
	input  wire pin_evt_s    det_async,
	// same-domain events
	input  wire logic        comm_valid,
	input  wire logic        balance_done,
	// mode and control outputs
	output pwr_state_e       mode,
	output func_en_s         func_en,
	output logic             digital_reset,
	output logic             uart_reset,
	output logic             otp_reload,
	output logic             circuits_off
);
	localparam int TICK_W = $clog2(TICK_CYCLES);
	localparam int HW_W   = $clog2(HWRST_CYCLES);

	pwr_state_e         state_reg;
	pwr_state_e         state_next;
	pin_evt_s           det_lvl;
	pin_evt_s           det_rise;
	logic [PIN_EVT_W-1:0] lvl_vec;
	logic [PIN_EVT_W-1:0] rise_vec;
	logic [TICK_W-1:0]  tick_cnt_reg;
	logic               tick;
	logic [HW_W-1:0]    hw_cnt_reg;
	logic [5:0]         xcfg_reg;
	logic [5:0]         lcfg_reg;
	logic               digital_reset_flag_reg;
	logic               commclr_reg;
	logic               fcomm_reg;
	logic               dig_rst;
	logic               uart_rst;
	logic               wake_from_sd;
	logic               hw_start;
	logic               link_exp;
	logic               sleep_exp;
	logic               active;
	logic               access;
	logic               wr_ok;
	logic               mapped;
	logic               sel_ctrl;
	logic               sel_xcfg;
	logic               sel_lcfg;
	logic               sel_stat;
	logic               sel_sys;
	logic               sel_c1;
	logic               sel_c3;
	logic               sw_shdn;
	logic               sw_sleep;
	logic               shdn_cause;
	logic               sleep_cause;
	logic               cfg_reset;
	logic [31:0]        rd_mux;

	// permitted functions per mode
	function automatic func_en_s func_for(input pwr_state_e s);
		func_en_s f;
		f = '0;
		if (s == ST_ACTIVE) begin
			f = '1;
			f.sleep_timeout = 1'b0;
		end else if (s == ST_SLEEP) begin
			f.cell_bal      = 1'b1;
			f.protectors    = 1'b1;
			f.fault_sig     = 1'b1;
			f.sleep_timeout = 1'b1;
			f.therm_detect  = 1'b1;
		end
		return f;
	endfunction : func_for

	pin_sync #(.WIDTH(PIN_EVT_W)) u_sync (
		.clk      (pclk),
		.rstn     (presetn),
		.async_in (det_async),
		.level    (lvl_vec),
		.rise     (rise_vec)
	);
	assign det_lvl  = pin_evt_s'(lvl_vec);
	assign det_rise = pin_evt_s'(rise_vec);

	// slow tick for timeouts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= '0;
		end else if (tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
		end
	end
	assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

	assign active = (state_reg == ST_ACTIVE);

	idle_timer #(.W(16)) u_link_to (
		.clk     (pclk),
		.rstn    (presetn),
		.tick    (tick),
		.run     (active && lcfg_reg[LINK_EN_BIT]),
		.restart (comm_valid || access),
		.limit   (timeout_ticks(lcfg_reg[LINK_SEL_LSB +: 3])),
		.expired (link_exp)
	);

	idle_timer #(.W(16)) u_sleep_to (
		.clk     (pclk),
		.rstn    (presetn),
		.tick    (tick),
		.run     (state_reg == ST_SLEEP),
		.restart (1'b0),
		.limit   (timeout_ticks(xcfg_reg[SLP_SEL_LSB +: 3])),
		.expired (sleep_exp)
	);

	// apb decode
	always_comb begin
		sel_ctrl = 1'b0;
		sel_xcfg = 1'b0;
		sel_lcfg = 1'b0;
		sel_stat = 1'b0;
		sel_sys  = 1'b0;
		sel_c1   = 1'b0;
		sel_c3   = 1'b0;
		if (paddr == CTRL_OFS) begin
			sel_ctrl = 1'b1;
		end else if (paddr == XCFG_OFS) begin
			sel_xcfg = 1'b1;
		end else if (paddr == LCFG_OFS) begin
			sel_lcfg = 1'b1;
		end else if (paddr == STAT_OFS) begin
			sel_stat = 1'b1;
		end else if (paddr == SYSFLT_OFS) begin
			sel_sys = 1'b1;
		end else if (paddr == COMMFLT1_OFS) begin
			sel_c1 = 1'b1;
		end else if (paddr == COMMFLT3_OFS) begin
			sel_c3 = 1'b1;
		end
	end
	assign mapped  = sel_ctrl | sel_xcfg | sel_lcfg | sel_stat | sel_sys | sel_c1 | sel_c3;
	assign access  = psel && penable;
	assign pready  = 1'b1;
	// writes outside ACTIVE are refused
	assign pslverr = access && (!mapped || (pwrite && !active));
	assign wr_ok   = access && pwrite && mapped && active;

	// broadcast writes arrive here as ordinary writes
	assign sw_shdn  = wr_ok && sel_ctrl && pwdata[SHUTDOWN_REQ_BIT];
	assign sw_sleep = wr_ok && sel_ctrl && pwdata[SLEEP_REQ_BIT];

	assign shdn_cause = det_rise.shutdown || det_lvl.thermal
		|| (balance_done && xcfg_reg[BAL_SHDN_EN_BIT]);
	assign sleep_cause = sw_sleep || (link_exp && !lcfg_reg[LINK_TO_SHDN_BIT]);

	// mode transitions, hard reset first, then shutdown, then sleep
	always_comb begin
		state_next   = state_reg;
		dig_rst      = 1'b0;
		uart_rst     = 1'b0;
		wake_from_sd = 1'b0;
		hw_start     = 1'b0;
		case (state_reg)
			ST_POR: begin
				state_next = ST_SHUTDOWN;
			end
			ST_HWRST: begin
				if (hw_cnt_reg == '0) begin
					state_next = ST_SHUTDOWN;
				end
			end
			ST_SHUTDOWN: begin
				if (det_rise.hard_reset) begin
					state_next = ST_HWRST;
					hw_start   = 1'b1;
				end else if (det_rise.wake) begin
					state_next   = ST_ACTIVE;
					dig_rst      = 1'b1;
					wake_from_sd = 1'b1;
				end
			end
			ST_SLEEP: begin
				if (det_rise.hard_reset) begin
					state_next = ST_HWRST;
					hw_start   = 1'b1;
				end else if (shdn_cause || sleep_exp) begin
					state_next = ST_SHUTDOWN;
				end else if (det_rise.wake) begin
					state_next = ST_ACTIVE;
					dig_rst    = 1'b1;
				end else if (det_rise.sleep_exit) begin
					state_next = ST_ACTIVE;
					uart_rst   = 1'b1;
				end
			end
			ST_ACTIVE: begin
				if (det_rise.hard_reset) begin
					state_next = ST_HWRST;
					hw_start   = 1'b1;
				end else if (shdn_cause || sw_shdn
					|| (link_exp && lcfg_reg[LINK_TO_SHDN_BIT])) begin
					state_next = ST_SHUTDOWN;
				end else if (sleep_cause) begin
					state_next = ST_SLEEP;
				end else if (det_rise.wake) begin
					dig_rst = 1'b1;
				end else if (det_rise.sleep_exit) begin
					uart_rst = 1'b1;
				end
			end
			default: begin
				state_next = ST_SHUTDOWN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_POR;
		end else begin
			state_reg <= state_next;
		end
	end

	// circuits-off hold time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hw_cnt_reg <= '0;
		end else if (hw_start) begin
			hw_cnt_reg <= HW_W'(HWRST_CYCLES - 1);
		end else if (hw_cnt_reg != '0) begin
			hw_cnt_reg <= hw_cnt_reg - HW_W'(1);
		end
	end

	// outputs registered from next state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_en       <= '0;
			digital_reset <= 1'b0;
			uart_reset    <= 1'b0;
			otp_reload    <= 1'b0;
			circuits_off  <= 1'b0;
		end else begin
			func_en       <= func_for(state_next);
			digital_reset <= dig_rst;
			uart_reset    <= uart_rst;
			otp_reload    <= dig_rst;
			circuits_off  <= (state_next == ST_HWRST);
		end
	end
	assign mode = state_reg;

	// configuration, returned to defaults by any digital reset
	assign cfg_reset = dig_rst || hw_start;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xcfg_reg <= XCFG_RST;
			lcfg_reg <= LCFG_RST;
		end else if (cfg_reset) begin
			xcfg_reg <= XCFG_RST;
			lcfg_reg <= LCFG_RST;
		end else if (wr_ok && sel_xcfg) begin
			xcfg_reg <= pwdata[5:0];
		end else if (wr_ok && sel_lcfg) begin
			lcfg_reg <= pwdata[5:0];
		end
	end

	// reset-related flags: set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			digital_reset_flag_reg <= 1'b0;
		end else if (hw_start) begin
			digital_reset_flag_reg <= 1'b0;
		end else if (dig_rst) begin
			digital_reset_flag_reg <= 1'b1;
		end else if (wr_ok && sel_sys && pwdata[DIGITAL_RESET_FLAG_BIT]) begin
			digital_reset_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fcomm_reg <= 1'b0;
		end else if (hw_start) begin
			fcomm_reg <= 1'b0;
		end else if (wake_from_sd && !is_top) begin
			fcomm_reg <= 1'b1;
		end else if (wr_ok && sel_c3 && pwdata[FCOMM_BIT]) begin
			fcomm_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			commclr_reg <= 1'b0;
		end else if (hw_start) begin
			commclr_reg <= 1'b0;
		end else if (is_base && (wake_from_sd || uart_rst)) begin
			commclr_reg <= 1'b1;
		end else if (wr_ok && sel_c1 && pwdata[COMMCLR_BIT]) begin
			commclr_reg <= 1'b0;
		end
	end

	// read data, captured in the setup phase
	always_comb begin
		rd_mux = RD_ZERO;
		if (sel_xcfg) begin
			rd_mux[5:0] = xcfg_reg;
		end else if (sel_lcfg) begin
			rd_mux[5:0] = lcfg_reg;
		end else if (sel_stat) begin
			rd_mux[STAT_MODE_LSB +: 5]      = state_reg;
			rd_mux[STAT_FUNC_LSB +: FUNC_W] = func_en;
		end else if (sel_sys) begin
			rd_mux[DIGITAL_RESET_FLAG_BIT] = digital_reset_flag_reg;
		end else if (sel_c1) begin
			rd_mux[COMMCLR_BIT] = commclr_reg;
		end else if (sel_c3) begin
			rd_mux[FCOMM_BIT] = fcomm_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= RD_ZERO;
		end else if (psel && !penable) begin
			prdata <= rd_mux;
		end
	end
endmodule : power_mode_controller

// ---- power_mode_controller_chk.sv ----
// port assertions for the power mode controller
`timescale 1ns/10ps
module power_mode_controller_chk
	import power_mode_pkg::*;
#(
	parameter int HWRST_CYCLES = 6
) (
	// clock, reset, bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	// events and outputs
	input wire pin_evt_s    det_async,
	input wire pwr_state_e  mode,
	input wire func_en_s    func_en,
	input wire logic        digital_reset,
	input wire logic        uart_reset,
	input wire logic        otp_reload,
	input wire logic        circuits_off
);
	logic [15:0] hw_cnt;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hw_cnt <= 16'h0000;
		else
			hw_cnt <= (mode == ST_HWRST) ? hw_cnt + 16'h0001 : 16'h0000;
	end

	sequence wake_s;
		mode == ST_SHUTDOWN ##1 mode == ST_ACTIVE;
	endsequence
	sequence slp_wake_s;
		mode == ST_SLEEP ##1 mode == ST_ACTIVE;
	endsequence
	sequence sw_shdn_s;
		psel && penable && pwrite && paddr == CTRL_OFS && pwdata[SHUTDOWN_REQ_BIT]
			&& mode == ST_ACTIVE;
	endsequence

	por_settle_a: assert property (mode == ST_POR |=> mode == ST_SHUTDOWN)
		else $error("power-on state did not settle in shutdown");
	shdn_exit_a: assert property (mode == ST_SHUTDOWN ##1 mode != ST_SHUTDOWN |->
		mode == ST_ACTIVE || mode == ST_HWRST) else $error("illegal exit from shutdown");
	wake_reset_a: assert property (wake_s |-> ##[0:1] (digital_reset && otp_reload))
		else $error("wake from shutdown without digital reset");
	sleep_entry_a: assert property ($changed(mode) && mode == ST_SLEEP |->
		$past(mode) == ST_ACTIVE) else $error("sleep entered from a mode other than active");
	func_map_a: assert property (func_en == (mode == ST_ACTIVE ? 12'hffd :
		mode == ST_SLEEP ? 12'h01f : 12'h000)) else $error("function enables wrong for mode");
	hw_off_a: assert property (circuits_off == (mode == ST_HWRST))
		else $error("circuits off does not follow hard reset state");
	hw_len_a: assert property (mode == ST_HWRST |-> hw_cnt < HWRST_CYCLES)
		else $error("hard reset state held too long");
	hw_exit_a: assert property ($fell(mode == ST_HWRST) |-> mode == ST_SHUTDOWN)
		else $error("hard reset did not restart in shutdown");
	refuse_wr_a: assert property (psel && penable && pwrite && mode != ST_ACTIVE |-> pslverr)
		else $error("write accepted outside active");
	sw_shdn_a: assert property (sw_shdn_s |-> ##[1:2] mode == ST_SHUTDOWN)
		else $error("shutdown request not obeyed");
	therm_a: assert property (det_async.thermal [*8] |-> mode != ST_ACTIVE && mode != ST_SLEEP)
		else $error("hot die left running");
	sleep_exit_a: assert property (slp_wake_s |-> digital_reset != uart_reset)
		else $error("sleep exit without exactly one of digital or uart reset");
endmodule : power_mode_controller_chk

bind power_mode_controller power_mode_controller_chk #(.HWRST_CYCLES(HWRST_CYCLES))
	power_mode_controller_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pslverr, .det_async, .mode, .func_en, .digital_reset, .uart_reset, .otp_reload,
	.circuits_off);

// ---- host_pinger.sv ----
// host side model: pings, tones and die temperature
`timescale 1ns/10ps
module host_pinger
	import power_mode_pkg::*;
(
	// clock
	input  wire logic pclk,
	// detector lines toward the device
	output pin_evt_s  det_async
);
	logic [4:0] pulse;
	logic       hot;

	initial begin
		pulse = 5'h00;
		hot = 1'b0;
	end
	assign det_async = pin_evt_s'(pulse | {4'h0, hot});

	// held past the device filter, then quiet while it reacts
	task automatic send(input logic [4:0] evt);
		@(posedge pclk);
		pulse <= evt;
		repeat (6) @(posedge pclk);
		pulse <= 5'h00;
		repeat (8) @(posedge pclk);
	endtask : send

	task automatic heat(input logic v);
		@(posedge pclk);
		hot <= v;
	endtask : heat
endmodule : host_pinger

// ---- power_mode_controller_tb_top.sv ----
// self-checking bench for the power mode controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module power_mode_controller_tb_top
	import power_mode_pkg::*;
;
	localparam int TK = 4;
	localparam int HW = 6;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, is_base, is_top, comm_valid, balance_done;
	pin_evt_s    det_async;
	pwr_state_e  mode;
	func_en_s    func_en;
	logic        digital_reset, uart_reset, otp_reload, circuits_off;
	int          fails, total_checks;
	logic [11:0] flt [3];

	power_mode_controller #(.TICK_CYCLES(TK), .HWRST_CYCLES(HW)) power_mode_controller_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .is_base, .is_top, .det_async, .comm_valid, .balance_done, .mode,
		.func_en, .digital_reset, .uart_reset, .otp_reload, .circuits_off);
	host_pinger host_pinger_inst (.pclk, .det_async);

	initial pclk = 1'b0;
	always #10 pclk = ~pclk;

	// one transfer; a read compares against d
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			input logic ee);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the watchdog ends a slave that never answers
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		`CHK("pslverr", ee, pslverr)
		if (!wr) `CHK("prdata", d, prdata)
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wait_mode(input pwr_state_e m, input int lim);
		int n;
		n = 0;
		@(negedge pclk);
		while (mode !== m && n < lim) begin
			n++;
			@(negedge pclk);
		end
		`CHK("mode", m, mode)
		@(posedge pclk);
	endtask : wait_mode

	task automatic wake_up;
		host_pinger_inst.send(5'h10);
		wait_mode(ST_ACTIVE, 4);
	endtask : wake_up

	task automatic wrap_up;
		if (fails == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		wrap_up();
	end

	initial begin
		{presetn, psel, penable, pwrite, comm_valid, balance_done, is_base, is_top} = 8'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		fails = 0;
		total_checks = 0;
		flt = '{SYSFLT_OFS, COMMFLT1_OFS, COMMFLT3_OFS};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		wait_mode(ST_SHUTDOWN, 4);
		apb(1'b0, STAT_OFS, 32'h0000_0002, 1'b0);
		apb(1'b1, CTRL_OFS, 32'h0000_0002, 1'b1);
		for (int p = 0; p < 3; p++) begin
			is_top <= (p == 0);
			is_base <= (p == 2);
			fork
				host_pinger_inst.send(5'h02);
				wait_mode(ST_HWRST, 10);
			join
			wait_mode(ST_SHUTDOWN, HW + 4);
			wake_up();
			apb(1'b0, SYSFLT_OFS, 32'h0000_0001, 1'b0);
			apb(1'b0, COMMFLT3_OFS, 32'(p != 0), 1'b0);
			apb(1'b0, COMMFLT1_OFS, 32'(p == 2), 1'b0);
			foreach (flt[i]) apb(1'b1, flt[i], 32'h0000_0001, 1'b0);
			foreach (flt[i]) apb(1'b0, flt[i], 32'h0000_0000, 1'b0);
		end
		apb(1'b0, 12'h0ff, 32'h0000_0000, 1'b1);
		apb(1'b0, STAT_OFS, 32'h000f_fd08, 1'b0);
		apb(1'b1, XCFG_OFS, 32'h0000_0001, 1'b0);
		apb(1'b1, CTRL_OFS, 32'h0000_0002, 1'b0);
		wait_mode(ST_SLEEP, 4);
		apb(1'b0, STAT_OFS, 32'h0000_1f04, 1'b0);
		host_pinger_inst.send(5'h08);
		wait_mode(ST_ACTIVE, 4);
		apb(1'b0, XCFG_OFS, 32'h0000_0001, 1'b0);
		apb(1'b0, SYSFLT_OFS, 32'h0000_0000, 1'b0);
		apb(1'b0, COMMFLT1_OFS, 32'h0000_0001, 1'b0);
		apb(1'b1, COMMFLT1_OFS, 32'h0000_0001, 1'b0);
		apb(1'b1, CTRL_OFS, 32'h0000_0002, 1'b0);
		wait_mode(ST_SLEEP, 4);
		repeat (100) @(posedge pclk);
		wait_mode(ST_SLEEP, 0);
		wait_mode(ST_SHUTDOWN, 60);
		wake_up();
		apb(1'b0, XCFG_OFS, 32'h0000_0000, 1'b0);
		apb(1'b1, LCFG_OFS, 32'h0000_0011, 1'b0);
		wait_mode(ST_SLEEP, 160);
		wake_up();
		apb(1'b0, LCFG_OFS, 32'h0000_0000, 1'b0);
		apb(1'b1, LCFG_OFS, 32'h0000_0031, 1'b0);
		// frames keep the link timer from expiring
		for (int k = 0; k < 3; k++) begin
			repeat (100) @(posedge pclk);
			comm_valid <= 1'b1;
			@(posedge pclk);
			comm_valid <= 1'b0;
		end
		wait_mode(ST_ACTIVE, 0);
		wait_mode(ST_SHUTDOWN, 160);
		wake_up();
		apb(1'b1, XCFG_OFS, 32'h0000_0001, 1'b0);
		wake_up();
		apb(1'b0, XCFG_OFS, 32'h0000_0000, 1'b0);
		apb(1'b1, XCFG_OFS, 32'h0000_0010, 1'b0);
		apb(1'b1, CTRL_OFS, 32'h0000_0002, 1'b0);
		wait_mode(ST_SLEEP, 4);
		balance_done <= 1'b1;
		wait_mode(ST_SHUTDOWN, 8);
		balance_done <= 1'b0;
		wake_up();
		host_pinger_inst.heat(1'b1);
		wait_mode(ST_SHUTDOWN, 10);
		host_pinger_inst.heat(1'b0);
		repeat (8) @(posedge pclk);
		wake_up();
		host_pinger_inst.send(5'h04);
		wait_mode(ST_SHUTDOWN, 2);
		wake_up();
		apb(1'b1, CTRL_OFS, 32'h0000_0003, 1'b0);
		wait_mode(ST_SHUTDOWN, 4);
		wake_up();
		fork
			host_pinger_inst.send(5'h06);
			wait_mode(ST_HWRST, 10);
		join
		wait_mode(ST_SHUTDOWN, HW + 4);
		wrap_up();
	end
endmodule : power_mode_controller_tb_top
